// ### bench/lps_link_props.sv
// lps_link_props: assertions on the pins between sequencer and controller
// assumes clk and rstn_i are the system clock and its async active-low reset
`timescale 1ns/1ns
module lps_link_props
(
  // system
  input wire logic clk,
  input wire logic rstn_i,
  // link pins
  input wire logic start,
  input wire logic scan_clk,
  input wire logic pix_oe
);
  // ----
  // scan clock rises counted from the start rise
  // ----
  logic sc_r;
  logic st_r;
  logic [7:0] edge_cnt_r;
  logic [7:0] edge_cnt_nxt;
  logic sc_rise;
  logic st_rise;
  assign sc_rise = scan_clk & ~sc_r;
  assign st_rise = start & ~st_r;
  // 8'hff means idle; it stops there
  assign edge_cnt_nxt = st_rise ? 8'h00 : ((sc_rise && edge_cnt_r != 8'hff) ? edge_cnt_r + 8'h01 : edge_cnt_r);
  // edge history
  always_ff @(posedge clk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sc_r <= 1'b0;
      st_r <= 1'b0;
      edge_cnt_r <= 8'hff;
    end
    else
    begin
      sc_r <= scan_clk;
      st_r <= start;
      edge_cnt_r <= edge_cnt_nxt;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn_i);
  chk_start_first_rise: assert property (sc_rise && edge_cnt_r == 8'h00 |-> start)
    else $error("start low at first scan rise");
  chk_start_low_next: assert property (sc_rise && edge_cnt_r == 8'h01 |-> !start)
    else $error("start still high at second scan rise");
  chk_start_clk_low: assert property ($changed(start) |-> !scan_clk)
    else $error("start moved while scan clock high");
  chk_restart_gap: assert property (st_rise |-> edge_cnt_r >= 8'h41)
    else $error("start before the earliest restart rise");
  chk_out_driven: assert property (sc_rise && edge_cnt_r >= 8'h01 && edge_cnt_r <= 8'h3f |-> pix_oe)
    else $error("output not driven inside scan");
  chk_end_release: assert property (sc_rise && edge_cnt_r == 8'h40 |-> pix_oe ##[1:8] !pix_oe)
    else $error("output not released after the end rise");
  chk_release_count: assert property ($fell(pix_oe) |-> edge_cnt_r == 8'h41)
    else $error("output released at wrong rise count");
  chk_idle_hiz: assert property (edge_cnt_r > 8'h41 |-> !pix_oe)
    else $error("output driven after scan");
  chk_pre_hiz: assert property (edge_cnt_r == 8'h00 |-> !pix_oe)
    else $error("output driven before first rise");
endmodule

// ### bench/tb.sv
// tb: both ends joined by the link; scans read through the pixel stream
// assumes the pixel integrators saturate well before each sample
`timescale 1ns/1ns
module tb;
  import lps_pkg::*;
  // lit pixels read 8'hff, dark ones 8'h00
  localparam logic [PIXEL_COUNT-1:0] LIGHT = 64'hf0e1_d2c3_b4a5_9687;
  logic clk_i;
  logic rstn_i;
  logic scan_req_i;
  logic [15:0] gap_edges_i;
  logic busy_o;
  logic pix_valid_o;
  logic [SAMPLE_W-1:0] pix_data_o;
  logic pix_ready_i;
  logic [PIXEL_COUNT-1:0] light_i;
  logic [PIXEL_COUNT-1:0] integ_clr_o;
  logic [PIXEL_COUNT-1:0] clr_seen;
  int clr_tot;
  int error_cnt;
  int checked;
  // ----
  // both ends and the checker
  // ----
  lps_link_if link (.clk(clk_i));
  lps_sensor i_lps_sensor (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .light_i(light_i),
    .integ_clr_o(integ_clr_o));
  lps_ctrl i_lps_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .scan_req_i(scan_req_i),
    .gap_edges_i(gap_edges_i), .busy_o(busy_o), .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
    .pix_ready_i(pix_ready_i));
  lps_link_props i_lps_link_props (.clk(link.clk), .rstn_i(rstn_i), .start(link.start),
    .scan_clk(link.scan_clk), .pix_oe(link.pix_oe));
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // integrator clears seen per scan
  always @(posedge clk_i)
  begin
    clr_seen <= clr_seen | integ_clr_o;
    clr_tot <= clr_tot + $countones(integ_clr_o);
  end
  // ----
  // tasks
  // ----
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up(input string what);
    error_cnt++;
    $display("BAD %s expected event seen timeout", what);
    print_verdict();
  endtask
  // request a scan and wait until the controller takes it
  task automatic do_scan(input logic [15:0] gap);
    int n;
    clr_seen = '0;
    clr_tot = 0;
    scan_req_i = 1'b1;
    gap_edges_i = gap;
    n = 0;
    while (busy_o !== 1'b1 && n < 300)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 300) give_up("busy_o");
    scan_req_i = 1'b0;
  endtask
  // take 64 words in pixel order, ready held high throughout; each word is
  // looked at on a falling edge while it stands and leaves on the next rise
  task automatic read_scan();
    int n;
    pix_ready_i = 1'b1;
    for (int k = 0; k < PIXEL_COUNT; k++)
    begin
      n = 0;
      while (pix_valid_o !== 1'b1 && n < 400)
      begin
        @(negedge clk_i);
        n++;
      end
      if (n >= 400) give_up("pix_valid_o");
      check("pix_data_o", {8'h00, pix_data_o}, LIGHT[k] ? 16'h00ff : 16'h0000);
      @(negedge clk_i);
    end
    pix_ready_i = 1'b0;
  endtask
  // scan finished: idle pin, stream empty, every pixel cleared once
  task automatic scan_end();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 4000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 4000) give_up("busy_o low");
    check("pix_valid", link.pix_valid, 1'b0);
    check("pix_valid_o", pix_valid_o, 1'b0);
    check("clr_tot", 16'(clr_tot), 16'h0040);
    check("clr_all", {15'h0000, &clr_seen}, 16'h0001);
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    error_cnt = 0;
    checked = 0;
    rstn_i = 1'b0;
    scan_req_i = 1'b0;
    gap_edges_i = 16'h0000;
    pix_ready_i = 1'b0;
    light_i = LIGHT;
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (400) @(negedge clk_i);
    check("pix_valid", link.pix_valid, 1'b0);
    check("busy_o", busy_o, 1'b0);
    // reader stalls: fifo fills and the scan must wait
    do_scan(16'h0000);
    repeat (3000) @(negedge clk_i);
    check("busy_o", busy_o, 1'b1);
    check("pix_valid_o", pix_valid_o, 1'b1);
    read_scan();
    scan_end();
    // back-to-back scan, reader keeping pace, longer gap
    do_scan(16'h0003);
    read_scan();
    scan_end();
    // reset in mid-scan returns both ends to idle
    do_scan(16'h0000);
    repeat (600) @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("pix_valid", link.pix_valid, 1'b0);
    check("busy_o", busy_o, 1'b0);
    check("pix_valid_o", pix_valid_o, 1'b0);
    rstn_i = 1'b1;
    repeat (400) @(negedge clk_i);
    do_scan(16'h0001);
    read_scan();
    scan_end();
    print_verdict();
  end
endmodule

// ### logic/lps_ctrl.sv
// lps_ctrl: controller end; makes the scan clock, the start pulse, and collects pixels
// assumes the sequencer answers on the link; pixels leave through an 8-word FIFO
`timescale 1ns/1ns
module lps_ctrl
  import lps_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rstn_i,
  // link
  lps_link_if.ctrl link,
  // scan request; gap edges after the 66th set integration time
  input wire logic scan_req_i,
  input wire logic [15:0] gap_edges_i,
  output logic busy_o,
  // pixel stream
  output logic pix_valid_o,
  output logic [SAMPLE_W-1:0] pix_data_o,
  input wire logic pix_ready_i
);
  // ----------------------------------------
  // scan clock divider
  // ----------------------------------------
  logic [HALF_CNT_W-1:0] half_r;
  logic sclk_r, start_r, busy_r;
  lps_state_t state_r;
  logic [EDGE_CNT_W-1:0] edge_r;
  logic [15:0] gap_r;
  logic pv_m_r, pv_s_r, fifo_rdy_w;
  logic [SAMPLE_W-1:0] pd_m_r, pd_s_r;
  wire half_end_w = (half_r == HALF_LAST);
  // rising edge next cycle; stall low phase while the FIFO is full
  wire rise_w = half_end_w & ~sclk_r & fifo_rdy_w;
  wire fall_w = half_end_w & sclk_r;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      half_r <= '0;
      sclk_r <= 1'b0;
    end
    else if (!half_end_w)
      half_r <= half_r + 1'b1;
    else if (rise_w || fall_w)
    begin
      half_r <= '0;
      sclk_r <= ~sclk_r;
    end
  end

  // ----------------------------------------
  // scan sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= LPS_IDLE;
      start_r <= 1'b0;
      edge_r <= '0;
      gap_r <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      // start changes at the falling edge so it is stable across one rising edge
      if (fall_w)
      begin
        case (state_r)
          LPS_IDLE:
            if (scan_req_i)
            begin
              start_r <= 1'b1;
              state_r <= LPS_SCAN;
              busy_r <= 1'b1;
              gap_r <= gap_edges_i;
            end
          LPS_SCAN:
          begin
            start_r <= 1'b0;
            // edges counted from the start edge; edge 65 always given
            if (edge_r >= EDGE_RESTART - 8'h01)
              state_r <= LPS_GAP;
          end
          LPS_GAP:
            if (gap_r == '0)
            begin
              state_r <= LPS_IDLE;
              busy_r <= 1'b0;
            end
          default:
            state_r <= LPS_IDLE;
        endcase
      end
      if (rise_w)
      begin
        if (state_r == LPS_SCAN)
          edge_r <= edge_r + 8'h01;
        else
          edge_r <= '0;
        if (state_r == LPS_GAP && gap_r != '0)
          gap_r <= gap_r - 16'h0001;
      end
    end
  end
  assign link.scan_clk = sclk_r;
  assign link.start = start_r;
  assign busy_o = busy_r;

  // ----------------------------------------
  // pixel capture into the FIFO
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pv_m_r <= 1'b0;
      pv_s_r <= 1'b0;
      pd_m_r <= SAMPLE_RST;
      pd_s_r <= SAMPLE_RST;
    end
    else
    begin
      pv_m_r <= link.pix_valid;
      pv_s_r <= pv_m_r;
      pd_m_r <= link.pix_seen;
      pd_s_r <= pd_m_r;
    end
  end
  // sample once per pixel, just before the next rising edge when settled
  wire push_w = rise_w & pv_s_r;
  lps_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_w),
    .in_data_i(pd_s_r),
    .in_ready_o(fifo_rdy_w),
    .out_valid_o(pix_valid_o),
    .out_data_o(pix_data_o),
    .out_ready_i(pix_ready_i)
  );
endmodule

// ### logic/lps_fifo.sv
// lps_fifo: small valid/ready FIFO with parameter width and depth
// assumes one clock; depth is a power of two
`timescale 1ns/1ns
module lps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // system
  input wire logic clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, rp_r;
  wire full_w = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty_w = (wp_r == rp_r);
  wire push_w = in_valid_i & ~full_w;
  wire pop_w = out_ready_i & ~empty_w;
  assign in_ready_o = ~full_w;
  assign out_valid_o = ~empty_w;
  assign out_data_o = mem_r[rp_r[AW-1:0]];
  // storage
  always_ff @(posedge clk_i)
  begin
    if (push_w)
      mem_r[wp_r[AW-1:0]] <= in_data_i;
  end
  // pointers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push_w)
        wp_r <= wp_r + 1'b1;
      if (pop_w)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// ### logic/lps_sensor.sv
// lps_sensor: 64-stage scan sequencer of a linear photodiode array
// assumes start and scan clock arrive from pins; both pass two flip-flops before use
// assumes light_i holds one level per pixel; a lit pixel gains one count per clock
// Notes on behaviour
// - one start high across one edge starts scan
// - token shifts one stage per edge, 64 stages
// - token stage selects that pixel to output
// - stage falling low clears that pixel integrator
// - 65th edge shifts token out, output released
// - controller always gives the 65th clock edge
// - next start no earlier than 66th edge
// - start low again before the next edge
// - output high impedance outside scan output phase
// - scan spacing sets the integration time
`timescale 1ns/1ns
module lps_sensor
  import lps_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rstn_i,
  // link
  lps_link_if.sensor link,
  // light input, one accumulation step per pixel
  input wire logic [PIXEL_COUNT-1:0] light_i,
  // integrator clear strobes, one per pixel
  output logic [PIXEL_COUNT-1:0] integ_clr_o
);
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic start_m_r;
  logic start_s_r;
  logic sclk_m_r;
  logic sclk_s_r;
  logic sclk_d_r;
  logic [PIXEL_COUNT-1:0] light_m_r;
  logic [PIXEL_COUNT-1:0] light_s_r;
  // start pin: two flops, only the second is read by the logic
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      start_m_r <= 1'b0;
      start_s_r <= 1'b0;
    end
    else
    begin
      start_m_r <= link.start;
      start_s_r <= start_m_r;
    end
  end
  // scan clock pin: two flops, then a delay stage for the edge detect;
  // all three reset low like the idle pin, so no false rise follows reset
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sclk_m_r <= link.scan_clk;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
    end
  end
  // light pins: two flops per pixel before the integrators count on them
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      light_m_r <= '0;
      light_s_r <= '0;
    end
    else
    begin
      light_m_r <= light_i;
      light_s_r <= light_m_r;
    end
  end
  // one-cycle pulse per scan clock rise
  wire rise_w = sclk_s_r & ~sclk_d_r;

  // ----------------------------------------
  // token shift register
  // ----------------------------------------
  logic [PIXEL_COUNT-1:0] token_r;
  wire [PIXEL_COUNT-1:0] token_nxt;
  genvar s;
  // stage 0 captures start; bit 63 has no successor, so it falls off on the 65th edge
  assign token_nxt[0] = start_s_r;
  generate
    for (s = 1; s < PIXEL_COUNT; s++)
    begin : g_stage
      assign token_nxt[s] = token_r[s-1];
    end
  endgenerate
  // one shift per scan clock rise; the register empties by itself after stage 63
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      token_r <= TOKEN_RST;
    else if (rise_w)
      token_r <= token_nxt;
  end

  // ----------------------------------------
  // latency through the block
  // ----------------------------------------
  // a pin edge reaches the second sync flop after 2 clocks
  // rise_w stands for the one cycle in which the delay stage still lags
  // token_r moves on the 3rd clock after the scan clock pin rises
  // oe_r and pix_r follow on the 4th clock, so each pixel stands for one
  // scan clock period, 4 clocks behind the pin's rising edges
  // start and scan clock share the same two-flop delay, so the start
  // level that stood across the pin's rise is the level captured
  // a scan clock level held for less than one clock may slip
  // past the edge detect; the controller holds each level much longer
  // a second start inside a running scan would shift a second token in
  // and present two pixels at once; the mux then shows the higher one

  // ----------------------------------------
  // per-pixel integrators and sample hold
  // ----------------------------------------
  logic [SAMPLE_W-1:0] integ_r [PIXEL_COUNT];
  logic [SAMPLE_W-1:0] held_r [PIXEL_COUNT];
  logic [PIXEL_COUNT-1:0] clr_w;
  // a stage going low on this edge resets its integrator
  assign clr_w = rise_w ? (token_r & ~token_nxt) : '0;
  genvar g;
  generate
    for (g = 0; g < PIXEL_COUNT; g++)
    begin : g_pix
      // integrator: counts while lit, saturates at all ones, and starts
      // over as the token leaves its stage
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          integ_r[g] <= SAMPLE_RST;
        else if (clr_w[g])
          integ_r[g] <= SAMPLE_RST;
        else if (light_s_r[g] && integ_r[g] != '1)
          integ_r[g] <= integ_r[g] + 8'h01;
      end
      // sampler: tracks the integrator, frozen from one stage ahead of
      // its own until the token has gone, so the presented value cannot
      // move under the output and the clear never reaches it
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          held_r[g] <= SAMPLE_RST;
        else if (!token_r[g] && !token_nxt[g])
          held_r[g] <= integ_r[g];
      end
    end
  endgenerate

  // ----------------------------------------
  // output mux and pin drive
  // ----------------------------------------
  // index of the one set stage; zero when the register is empty
  // starts are a scan apart, so at most one stage is high
  function automatic logic [PIX_IDX_W-1:0] lps_onehot_idx(input logic [PIXEL_COUNT-1:0] v);
    logic [PIX_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < PIXEL_COUNT; i++)
      if (v[i])
        idx = PIX_IDX_W'(i);
    return idx;
  endfunction
  wire active_w = |token_r;
  wire [PIX_IDX_W-1:0] sel_w = lps_onehot_idx(token_r);
  logic [SAMPLE_W-1:0] pix_r;
  logic oe_r;
  logic [PIXEL_COUNT-1:0] clr_r;
  // presented sample; zero while released, matching the pulldown
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pix_r <= SAMPLE_RST;
    else
      pix_r <= active_w ? held_r[sel_w] : SAMPLE_RST;
  end
  // pin enable follows token presence, so it drops one clock after
  // the 65th rise empties the register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      oe_r <= 1'b0;
    else
      oe_r <= active_w;
  end
  // integrator clear strobes, one clock each, out through a flop
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      clr_r <= '0;
    else
      clr_r <= clr_w;
  end
  // pins and strobes straight from the flops above
  assign link.pix_out = pix_r;
  assign link.pix_oe = oe_r;
  assign integ_clr_o = clr_r;
endmodule

// ### pkg/lps_link_if.sv
// lps_link_if: the pins between the sequencer and the controller
// assumes both ends sample on clk; the output pin level is resolved here from its enable
`timescale 1ns/1ns
interface lps_link_if
  import lps_pkg::*;
(
  input wire logic clk
);
  logic start;                  // start pulse from the controller
  logic scan_clk;               // scan clock from the controller
  logic [SAMPLE_W-1:0] pix_out; // pixel_voltage_out value from the sequencer
  logic pix_oe;                 // sequencer drives the output pin
  logic [SAMPLE_W-1:0] pix_seen;
  logic pix_valid;              // pin is driven, not high impedance

  // resolve the pin: a released pin reads as zero through its pulldown
  assign pix_seen = pix_oe ? pix_out : SAMPLE_RST;
  assign pix_valid = pix_oe;

  modport sensor (input start, input scan_clk, output pix_out, output pix_oe);
  modport ctrl (output start, output scan_clk, input pix_seen, input pix_valid);
endinterface

// ### pkg/lps_pkg.sv
// lps_pkg: constants and types shared by the scan sequencer, its controller and the link interface
// assumes a single 100 MHz system clock on both ends
package lps_pkg;
  // ----------------------------------------
  // array geometry and sample format
  // ----------------------------------------
  localparam int unsigned PIXEL_COUNT = 64;
  localparam int unsigned PIX_IDX_W = 6;
  localparam int unsigned SAMPLE_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // edge after the start edge that ends a scan, and earliest restart edge
  localparam int unsigned END_EDGE = 65;
  localparam int unsigned RESTART_EDGE = 66;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCLK_HALF_NS = 100; // half period of the scan clock
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HALF_CNT_W = 8;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SCLK_HALF_CYC - 1);
  localparam int unsigned EDGE_CNT_W = 8;
  localparam logic [EDGE_CNT_W-1:0] EDGE_END = EDGE_CNT_W'(END_EDGE);
  localparam logic [EDGE_CNT_W-1:0] EDGE_RESTART = EDGE_CNT_W'(RESTART_EDGE);
  localparam logic [PIXEL_COUNT-1:0] TOKEN_RST = '0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 8'h00;

  // controller sequencing states
  typedef enum logic [1:0] {LPS_IDLE, LPS_SCAN, LPS_GAP} lps_state_t;
endpackage
